// ### ssnt_pkg.sv
package ssnt_pkg;

    // data path shape: four byte lanes on one common bus
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;

    // storage depth in words, kept small because storage is flip-flops
    localparam int ADDR_W = 8;
    localparam int DEPTH = 1 << ADDR_W;

    // burst address counter
    localparam int BURST_W = 2;

    // pin filters for the inputs that do not follow the clock
    localparam int SYNC_STAGES = 3;
    localparam int ASY_N = 4;
    localparam int ASY_OE = 0;
    localparam int ASY_ORDER = 1;
    localparam int ASY_BYPASS = 2;
    localparam int ASY_SLEEP = 3;
    // reset levels: outputs off, linear order, pipelined, awake
    localparam logic [ASY_N-1:0] ASY_RESET = 4'h5;

    // cycles from a raised sleep request to sleep
    localparam int SLEEP_ENTRY_CYC = 2;

    // type of the burst that is running
    typedef enum logic [1:0] {
        SSNT_DESEL = 2'b00,
        SSNT_READ = 2'b01,
        SSNT_WRITE = 2'b10
    } ssnt_kind_t;

    // one late write waiting for its data edge
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes_n;
    } ssnt_wr_t;

endpackage

// ### ssnt_burst_ctr.sv
`timescale 1ns/100ps
module ssnt_burst_ctr #(
    parameter int CNT_W = ssnt_pkg::BURST_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic step,
    input wire logic interleave,
    input wire logic [CNT_W-1:0] start_lo,
    output logic [CNT_W-1:0] next_lo
);

    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] count_inc;

    ////////////////////////////////////////////////////////////////////////
    // address seen by the next continue cycle; width wrap gives the 4-step cycle
    assign count_inc = count + {{(CNT_W-1){1'b0}}, 1'b1};
    assign next_lo = interleave ? (start ^ count_inc) : (start + count_inc);

    ////////////////////////////////////////////////////////////////////////
    // load clears the count, every continue cycle steps it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start <= '0;
            count <= '0;
        end else if (load) begin
            start <= start_lo;
            count <= '0;
        end else if (step) begin
            count <= count_inc;
        end
    end

endmodule // ssnt_burst_ctr

// ### ssnt_sram_ctrl.sv
// Notes on behaviour
// - sync inputs sampled on rising edge only
// - active only with all three selects asserted
// - load edge with write high starts read
// - pipelined read data appears after next edge
// - selected enabled edge with write low writes
// - only lanes with low store bits written
// - all lane stores high aborts the write
// - pipelined write data taken at third edge
// - flow-through read data driven right away
// - flow-through write data taken at second edge
// - continue keeps first cycle type and selects
// - counter steps on every continue cycle
// - burst counter is two bits wide
// - read with outputs disabled is a no-op
// - load with any select inactive deselects
// - continue after deselect stays deselected
// - clock gate high freezes all but pin filters, sleep delay, output disable
// - stall keeps read driving, write floating
// - drivers off during writes regardless of enable
// - outputs float from power-up
// - linear order adds one modulo four
// - interleaved order xors start with count
// - bypass low flow-through, high pipelined
// - sleep entered two cycles after request
`timescale 1ns/100ps
module ssnt_sram_ctrl #(
    parameter int ADDR_W = ssnt_pkg::ADDR_W,
    parameter int DATA_W = ssnt_pkg::DATA_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en_n,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic write_n,
    input wire logic burst_step,
    input wire logic [ssnt_pkg::LANES-1:0] lane_store_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic out_en_n,
    input wire logic linear_order_n,
    input wire logic out_reg_bypass_n,
    input wire logic sleep_req,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);

    localparam int LANES = ssnt_pkg::LANES;
    localparam int LANE_W = ssnt_pkg::LANE_W;
    localparam int BW = ssnt_pkg::BURST_W;
    localparam int NA = ssnt_pkg::ASY_N;

    ////////////////////////////////////////////////////////////////////////
    // filters for the pins that do not follow mclk
    logic [NA-1:0] asy_s1;
    logic [NA-1:0] asy_s2;
    logic [NA-1:0] asy_s3;
    logic [NA-1:0] asy_f;
    logic [NA-1:0] asy_pin;

    assign asy_pin = {sleep_req, out_reg_bypass_n, linear_order_n, out_en_n};

    genvar gi;
    generate
        for (gi = 0; gi < NA; gi++) begin : g_asy
            // three stages; a change counts once stages two and three agree
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    asy_s1[gi] <= ssnt_pkg::ASY_RESET[gi];
                    asy_s2[gi] <= ssnt_pkg::ASY_RESET[gi];
                    asy_s3[gi] <= ssnt_pkg::ASY_RESET[gi];
                    asy_f[gi] <= ssnt_pkg::ASY_RESET[gi];
                end else begin
                    asy_s1[gi] <= asy_pin[gi];
                    asy_s2[gi] <= asy_s1[gi];
                    asy_s3[gi] <= asy_s2[gi];
                    if (asy_s2[gi] == asy_s3[gi]) begin
                        asy_f[gi] <= asy_s3[gi];
                    end
                end
            end
        end
    endgenerate

    wire oe_off = asy_f[ssnt_pkg::ASY_OE];
    wire interleave = asy_f[ssnt_pkg::ASY_ORDER];
    wire flow = ~asy_f[ssnt_pkg::ASY_BYPASS];
    wire sleep_lvl = asy_f[ssnt_pkg::ASY_SLEEP];

    ////////////////////////////////////////////////////////////////////////
    // sleep entry delay; leaving sleep is immediate so recovery is the caller's
    logic [ssnt_pkg::SLEEP_ENTRY_CYC-1:0] sleep_dly;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_dly <= '0;
        end else begin
            sleep_dly <= {sleep_dly[ssnt_pkg::SLEEP_ENTRY_CYC-2:0], sleep_lvl};
        end
    end

    wire sleep_on = sleep_lvl & sleep_dly[ssnt_pkg::SLEEP_ENTRY_CYC-1];

    ////////////////////////////////////////////////////////////////////////
    // command decode; controller pins share mclk so they are used as sampled
    ssnt_pkg::ssnt_kind_t burst_kind;
    ssnt_pkg::ssnt_kind_t next_kind;
    logic [ADDR_W-1:0] base_addr;
    logic [BW-1:0] next_lo;

    wire edge_on = ~clk_en_n & ~sleep_on;
    wire load = ~burst_step;
    wire sel_all = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
    wire wr_abort = &lane_store_n;

    // continue reuses the type of the first cycle, selects not looked at
    assign next_kind = !load ? burst_kind :
                       !sel_all ? ssnt_pkg::SSNT_DESEL :
                       write_n ? ssnt_pkg::SSNT_READ :
                       ssnt_pkg::SSNT_WRITE;

    wire [ADDR_W-1:0] cmd_addr = load ? addr : {base_addr[ADDR_W-1:BW], next_lo};
    // a read with outputs disabled touches nothing
    wire cmd_rd = (next_kind == ssnt_pkg::SSNT_READ) & ~oe_off;
    wire cmd_wr = (next_kind == ssnt_pkg::SSNT_WRITE) & ~wr_abort;

    ////////////////////////////////////////////////////////////////////////
    // burst type and address base, frozen while the edge is gated off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            burst_kind <= ssnt_pkg::SSNT_DESEL;
            base_addr <= '0;
        end else if (edge_on && load) begin
            burst_kind <= next_kind;
            base_addr <= addr;
        end
    end

    ssnt_burst_ctr #(
        .CNT_W(BW)
    ) u_burst (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(edge_on & load),
        .step(edge_on & ~load),
        .interleave(interleave),
        .start_lo(addr[BW-1:0]),
        .next_lo(next_lo)
    );

    ////////////////////////////////////////////////////////////////////////
    // late write queue: stage one then stage two, data edge picked by mode
    ssnt_pkg::ssnt_wr_t wq1;
    ssnt_pkg::ssnt_wr_t wq2;
    ssnt_pkg::ssnt_wr_t wq_take;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wq1 <= '0;
            wq2 <= '0;
        end else if (edge_on) begin
            wq1.valid <= cmd_wr;
            wq1.addr <= cmd_addr;
            wq1.lanes_n <= lane_store_n;
            wq2 <= flow ? '0 : wq1;
        end
    end

    // flow-through takes data one edge after the command, pipelined two
    assign wq_take = flow ? wq1 : wq2;
    wire wr_commit = edge_on & wq_take.valid;

    ////////////////////////////////////////////////////////////////////////
    // storage per lane, so each lane array has a single writer
    // no reset so contents survive sleep and stalls
    // limitation: a read of a word whose late write is still queued sees old data
    logic [DATA_W-1:0] rd_word;

    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            logic [LANE_W-1:0] lane_mem [ssnt_pkg::DEPTH];
            always_ff @(posedge mclk) begin
                if (wr_commit && !wq_take.lanes_n[gi]) begin
                    lane_mem[wq_take.addr] <= dq_in[gi*LANE_W +: LANE_W];
                end
            end
            assign rd_word[gi*LANE_W +: LANE_W] = lane_mem[cmd_addr];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read pipe: stage register feeds the pins one edge later when pipelined
    logic rd_pend;
    logic [DATA_W-1:0] rd_data;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend <= 1'b0;
            rd_data <= '0;
        end else if (edge_on) begin
            rd_pend <= cmd_rd & ~flow;
            rd_data <= rd_word;
        end
    end

    // what the pins should show after this edge
    wire drive_now = flow ? cmd_rd : rd_pend;
    wire [DATA_W-1:0] out_now = flow ? rd_word : rd_data;

    ////////////////////////////////////////////////////////////////////////
    // pin drivers; disable by output enable acts even during a stall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else if (sleep_on) begin
            dq_oe <= 1'b0;
        end else if (edge_on) begin
            dq_out <= out_now;
            dq_oe <= drive_now & ~oe_off;
        end else begin
            dq_oe <= dq_oe & ~oe_off;
        end
    end

endmodule // ssnt_sram_ctrl

// ### ssnt_ctl_model.sv
`timescale 1ns/100ps
module ssnt_ctl_model (
    input wire logic mclk,
    input wire logic clk_en_n,
    input wire logic flow,
    input wire logic wr_go,
    input wire logic [ssnt_pkg::DATA_W-1:0] wr_data,
    input wire logic dq_oe,
    input wire logic [ssnt_pkg::DATA_W-1:0] dq_out,
    output logic [ssnt_pkg::DATA_W-1:0] dq_in
);
    logic [ssnt_pkg::DATA_W:0] p0 = '0;
    logic [ssnt_pkg::DATA_W:0] p1 = '0;
    logic [ssnt_pkg::DATA_W-1:0] last = '0;
    wire logic [ssnt_pkg::DATA_W:0] due = flow ? p0 : p1;
    // late write data ages only on edges with the clock gate low
    always @(posedge mclk) begin
        if (!clk_en_n) begin
            p0 <= {wr_go, wr_data};
            p1 <= p0;
        end
        last <= dq_in;
    end
    // released bus shows due write data, else a toggling pattern, never a held value
    assign dq_in = dq_oe ? dq_out : due[ssnt_pkg::DATA_W] ? due[ssnt_pkg::DATA_W-1:0] : ~last;
endmodule // ssnt_ctl_model

// ### ssnt_sram_ctrl_assertions.sv
`timescale 1ns/100ps
module ssnt_chk #(
    parameter int DATA_W = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en_n,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic write_n,
    input wire logic burst_step,
    input wire logic out_en_n,
    input wire logic out_reg_bypass_n,
    input wire logic sleep_req,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe
);
    logic [3:0] cnt;
    logic [2:0] pins_q;
    // async pins pass a filter, so judge only once they have been quiet
    wire logic [2:0] pins = {out_en_n, out_reg_bypass_n, sleep_req};
    wire logic q8 = cnt == 4'h8;
    wire logic ok = q8 && !sleep_req;
    wire logic sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    wire logic ld = ok && !clk_en_n && !burst_step;
    wire logic rd = ld && sel && write_n && !out_en_n;
    wire logic wr = ld && sel && !write_n;
    wire logic pipe = out_reg_bypass_n;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            pins_q <= 3'h0;
        end else begin
            pins_q <= pins;
            cnt <= (pins != pins_q) ? 4'h0 : q8 ? cnt : cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_rd_pipe; rd && pipe ##1 !clk_en_n |=> dq_oe; endproperty
    a_rd_pipe: assert property (p_rd_pipe) else $error("pipelined read idle");
    property p_rd_flow; rd && !pipe |=> dq_oe; endproperty
    a_rd_flow: assert property (p_rd_flow) else $error("flow read idle");
    property p_wr_flow; wr && !pipe |=> !dq_oe; endproperty
    a_wr_flow: assert property (p_wr_flow) else $error("write drove bus");
    property p_desel; ld && !sel && !pipe |=> !dq_oe; endproperty
    a_desel: assert property (p_desel) else $error("deselect drove bus");
    property p_dcont; ld && !sel && !pipe ##1 (!clk_en_n && burst_step) |=> !dq_oe; endproperty
    a_dcont: assert property (p_dcont) else $error("deselect continue drove");
    property p_burst; rd && !pipe ##1 (!clk_en_n && burst_step) |=> dq_oe; endproperty
    a_burst: assert property (p_burst) else $error("burst read stopped");
    property p_stall; ok && clk_en_n |=> $stable(dq_oe) && $stable(dq_out); endproperty
    a_stall: assert property (p_stall) else $error("stall moved outputs");
    property p_noe; q8 && out_en_n |-> !dq_oe; endproperty
    a_noe: assert property (p_noe) else $error("driving while disabled");
    property p_sleep; q8 && sleep_req |-> !dq_oe; endproperty
    a_sleep: assert property (p_sleep) else $error("driving while asleep");
endmodule // ssnt_chk

// ### ssnt_sram_ctrl_bench.sv
`timescale 1ns/100ps
module ssnt_sram_ctrl_bench;
    logic mclk, rst_n, clk_en_n, chip_sel1_n, chip_sel2, chip_sel3_n, write_n, burst_step;
    logic out_en_n, linear_order_n, out_reg_bypass_n, sleep_req, dq_oe;
    logic wr_go, en_q, zz, b_s, b_w;
    logic [3:0] lane_store_n;
    logic [7:0] addr, b_a;
    logic [1:0] b_c;
    logic [31:0] dq_in, dq_out, wr_data, rnd;
    logic [31:0] mem [256];
    logic [31:0] q [$];
    int n_errors = 0, checks = 0, cyc = 0;
    ssnt_sram_ctrl u_ssnt_sram_ctrl (.mclk(mclk), .rst_n(rst_n), .clk_en_n(clk_en_n),
        .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n),
        .write_n(write_n), .burst_step(burst_step), .lane_store_n(lane_store_n), .addr(addr),
        .dq_in(dq_in), .out_en_n(out_en_n), .linear_order_n(linear_order_n),
        .out_reg_bypass_n(out_reg_bypass_n), .sleep_req(sleep_req), .dq_out(dq_out),
        .dq_oe(dq_oe));
    ssnt_ctl_model u_ssnt_ctl_model (.mclk(mclk), .clk_en_n(clk_en_n),
        .flow(!out_reg_bypass_n), .wr_go(wr_go), .wr_data(wr_data), .dq_oe(dq_oe),
        .dq_out(dq_out), .dq_in(dq_in));
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic miss(input string m);
        n_errors++;
        $display("MISMATCH %0t: %s", $time, m);
    endtask
    task automatic close_out;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one command; s steps the burst, v selects a load; expectations noted here
    task automatic op(input logic s, w, input logic [7:0] a, input logic [3:0] ln, input logic v);
        logic [7:0] ea;
        rnd = lfsr(rnd);
        @(posedge mclk);
        if (!s) {b_a, b_c, b_w, b_s} = {a, 2'h0, !w, v};
        else b_c = b_c + 2'h1;
        ea = {b_a[7:2], linear_order_n ? b_a[1:0] ^ b_c : b_a[1:0] + b_c};
        if (b_s && !zz && b_w) begin
            for (int i = 0; i < 4; i++) if (!ln[i]) mem[ea][8*i+:8] = rnd[8*i+:8];
        end else if (b_s && !zz && !out_en_n) q.push_back(mem[ea]);
        // a continue drops a select on purpose: it must be ignored
        {clk_en_n, chip_sel1_n, chip_sel2, chip_sel3_n} <= {1'b0, s, v, 1'b0};
        {write_n, burst_step, addr, lane_store_n} <= {w, s, a, ln};
        {wr_go, wr_data} <= {b_s && b_w && !zz, rnd};
    endtask
    task automatic idle(input int n);
        repeat (n) op(0, 1, 8'h00, 4'hf, 0);
    endtask
    task automatic stall(input int n);
        repeat (n) begin
            @(posedge mclk);
            clk_en_n <= 1'b1;
        end
    endtask
    // one note taken per acting edge while the bus is driven
    always @(posedge mclk) en_q <= !clk_en_n;
    always @(negedge mclk) begin
        if (rst_n && en_q && dq_oe === 1'b1) begin
            checks++;
            if (q.size() == 0) miss("bus driven with no read");
            else if (dq_out !== q.pop_front()) miss("read data");
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miss("timeout");
            close_out;
        end
    end
    initial begin
        {mclk, rst_n, chip_sel2, burst_step, out_en_n, linear_order_n, sleep_req} = '0;
        {clk_en_n, chip_sel1_n, chip_sel3_n, write_n, out_reg_bypass_n, lane_store_n} = '1;
        {addr, wr_data, b_a, b_c, b_s, b_w, en_q, wr_go, zz} = '0;
        rnd = 32'hfbc3_303f;
        repeat (12) @(posedge mclk);
        checks++;
        if (dq_oe !== 1'b0) miss("driving in reset");
        rst_n <= 1'b1;
        // every mode: pipelined/flow by linear/interleaved
        for (int m = 0; m < 4; m++) begin
            {out_reg_bypass_n, linear_order_n} <= {!m[1], m[0]};
            idle(10);
            for (int i = 0; i < 8; i++) op(0, 0, {6'h04, i[1:0]},
                i[2] ? ~(4'h1 << i[1:0]) : 4'h0, 1);
            op(0, 0, 8'h12, 4'hf, 1);
            op(0, 0, 8'h26, 4'h0, 1);
            op(1, 0, 8'h00, 4'h0, 1);
            stall(2);
            repeat (2) op(1, 0, 8'h00, 4'h0, 1);
            op(1, 0, 8'h00, 4'hf, 1);
            for (int i = 0; i < 4; i++) begin
                op(0, 1, {6'h04, i[1:0]}, 4'h0, 1);
                op(0, 0, {6'h0c, i[1:0]}, 4'h0, 1);
            end
            op(0, 1, 8'h25, 4'h0, 1);
            op(1, 1, 8'h00, 4'h0, 1);
            stall(1);
            repeat (3) op(1, 1, 8'h00, 4'h0, 1);
            op(0, 1, 8'h10, 4'h0, 0);
            op(1, 1, 8'h00, 4'h0, 0);
        end
        out_en_n <= 1'b1;
        idle(10);
        op(0, 1, 8'h10, 4'h0, 1);
        out_en_n <= 1'b0;
        sleep_req <= 1'b1;
        idle(10);
        zz = 1'b1;
        op(0, 0, 8'h10, 4'h0, 1);
        zz = 1'b0;
        sleep_req <= 1'b0;
        idle(10);
        op(0, 1, 8'h10, 4'h0, 1);
        idle(4);
        checks++;
        if (q.size() != 0) miss("read data missing");
        close_out;
    end
endmodule // ssnt_sram_ctrl_bench
bind ssnt_sram_ctrl ssnt_chk #(.DATA_W(DATA_W)) u_ssnt_chk (.mclk(mclk), .rst_n(rst_n),
    .clk_en_n(clk_en_n), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
    .chip_sel3_n(chip_sel3_n), .write_n(write_n), .burst_step(burst_step),
    .out_en_n(out_en_n), .out_reg_bypass_n(out_reg_bypass_n), .sleep_req(sleep_req),
    .dq_out(dq_out), .dq_oe(dq_oe));
